// ---- hdl/cfm_top.sv ----
// Clock frequency meter: register slave, reference control, counter
//
// Our own choices: the register offsets and the strobed register port.
module cfm_top #(
  parameter logic [11:0] VERSION_ID = 12'h0a1 // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [7:0] ref_sources,
  input wire logic [31:0] measured_sources,
  output logic ref_clock_on,
  output logic irq
);

  function automatic logic hit(input logic [9:0] a,
                               input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Register decode

  logic [31:0] mode_reg;
  logic [23:0] value_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_pending_reg;
  cfm_pkg::cfm_meas_e meas_state_reg;
  logic ref_switch_busy;
  logic ready_pulse;

  wire logic wr_ctrl = wr && hit(addr, cfm_pkg::OFS_CTRL);
  wire logic wr_mode = wr && hit(addr, cfm_pkg::OFS_MODE);
  wire logic wr_ier = wr && hit(addr, cfm_pkg::OFS_IRQ_ENABLE_SET);
  wire logic wr_idr = wr && hit(addr, cfm_pkg::OFS_IRQ_ENABLE_CLEAR);
  wire logic wr_icr = wr && hit(addr, cfm_pkg::OFS_IRQ_PENDING_CLEAR);
  wire logic start_cmd = wr_ctrl && wdata[cfm_pkg::CTRL_START_BIT];

  wire logic [2:0] ref_source_select =
    mode_reg[cfm_pkg::REF_SOURCE_SELECT_LSB +: cfm_pkg::REF_SOURCE_SELECT_W];
  wire logic [7:0] ref_cycle_count =
    mode_reg[cfm_pkg::REFCNT_LSB +: cfm_pkg::REFCNT_W];
  wire logic [4:0] measured_source_select =
    mode_reg[cfm_pkg::MSRSEL_LSB +: cfm_pkg::MSRSEL_W];

  wire logic meas_busy = (meas_state_reg != cfm_pkg::MEAS_IDLE);

  wire logic [31:0] status_word = {30'h0, ref_switch_busy, meas_busy};

  // Write-only and unmapped offsets read as zero
  wire logic [31:0] rd_mux =
    hit(addr, cfm_pkg::OFS_MODE) ? mode_reg :
    hit(addr, cfm_pkg::OFS_STATUS) ? status_word :
    hit(addr, cfm_pkg::OFS_VALUE) ? {8'h00, value_reg} :
    hit(addr, cfm_pkg::OFS_IRQ_MASK) ? {30'h0, irq_mask_reg} :
    hit(addr, cfm_pkg::OFS_IRQ_PENDING) ? {30'h0, irq_pending_reg} :
    hit(addr, cfm_pkg::OFS_VERSION) ? {20'h0, VERSION_ID} :
    32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_reg <= cfm_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wdata & cfm_pkg::MODE_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Clock inputs: synchronised, then selected
  // Sampling limits both sources to well under half of clk

  logic [7:0] ref_sync;
  logic [31:0] msr_sync;
  logic ref_prev_reg;
  logic msr_prev_reg;

  cfm_sync #(.W(cfm_pkg::REF_SRC_N)) u_ref_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(ref_sources),
    .sync_out(ref_sync)
  );

  cfm_sync #(.W(cfm_pkg::MSR_SRC_N)) u_msr_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(measured_sources),
    .sync_out(msr_sync)
  );

  wire logic ref_level = ref_sync[ref_source_select];
  wire logic msr_level = msr_sync[measured_source_select];
  wire logic ref_rise = rise(ref_level, ref_prev_reg);
  wire logic msr_rise = rise(msr_level, msr_prev_reg);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_prev_reg <= 1'b0;
      msr_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_level;
      msr_prev_reg <= msr_level;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Reference enable handshake

  cfm_ref_switch u_ref_switch (
    .clk(clk),
    .rstn(rstn),
    .en_write(wr_mode),
    .en_value(wdata[cfm_pkg::REFEN_BIT]),
    .ref_rise(ref_rise),
    .ref_on(ref_clock_on),
    .busy(ref_switch_busy),
    .ready_pulse(ready_pulse)
  );

  // Gated reference: no periods pass while it is off
  wire logic ref_tick = ref_rise && ref_clock_on;

  //////////////////////////////////////////////////////////////////////
  // Measurement
  // No halt input: debug halt has no effect on counting

  cfm_pkg::cfm_meas_e meas_state_next;
  logic [7:0] ref_done_reg;
  logic [23:0] edge_cnt_reg;

  wire logic [7:0] ref_done_inc = ref_done_reg + 8'h01;
  wire logic cnt_full = &edge_cnt_reg;
  // Saturates rather than wrapping, so overflow stays visible
  wire logic [23:0] edge_cnt_next =
    (msr_rise && !cnt_full) ? edge_cnt_reg + 24'h000001 : edge_cnt_reg;
  wire logic align_end = (meas_state_reg == cfm_pkg::MEAS_ALIGN) &&
    ref_tick && (ref_cycle_count == 8'h00);
  wire logic count_end = (meas_state_reg == cfm_pkg::MEAS_COUNT) &&
    ref_tick && (ref_done_inc == ref_cycle_count);
  wire logic meas_finish = align_end || count_end;

  always_comb begin
    meas_state_next = meas_state_reg;
    unique case (meas_state_reg)
      cfm_pkg::MEAS_IDLE: begin
        if (start_cmd) begin
          meas_state_next = cfm_pkg::MEAS_ALIGN;
        end
      end
      cfm_pkg::MEAS_ALIGN: begin
        // A stopped reference parks here or in counting
        if (meas_finish) begin
          meas_state_next = cfm_pkg::MEAS_IDLE;
        end else if (ref_tick) begin
          meas_state_next = cfm_pkg::MEAS_COUNT;
        end
      end
      cfm_pkg::MEAS_COUNT: begin
        if (meas_finish) begin
          meas_state_next = cfm_pkg::MEAS_IDLE;
        end
      end
      default: begin
        meas_state_next = cfm_pkg::MEAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meas_state_reg <= cfm_pkg::MEAS_IDLE;
    end else begin
      meas_state_reg <= meas_state_next;
    end
  end

  // Window opens on a reference edge, so it spans whole periods
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_done_reg <= 8'h00;
      edge_cnt_reg <= 24'h000000;
    end else if (meas_state_reg == cfm_pkg::MEAS_COUNT) begin
      edge_cnt_reg <= edge_cnt_next;
      if (ref_tick) begin
        ref_done_reg <= ref_done_inc;
      end
    end else begin
      ref_done_reg <= 8'h00;
      edge_cnt_reg <= 24'h000000;
    end
  end

  // Count of measured edges per window: the 24-bit ratio
  always_ff @(posedge clk) begin
    if (!rstn) begin
      value_reg <= cfm_pkg::VALUE_RESET[23:0];
    end else if (count_end) begin
      value_reg <= edge_cnt_next;
    end else if (align_end) begin
      value_reg <= 24'h000000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt mask and pending flags

  wire logic [1:0] irq_set = {ready_pulse, meas_finish};
  wire logic [1:0] pend_clr = wr_icr ? wdata[1:0] : 2'h0;
  wire logic [1:0] mask_set = wr_ier ? wdata[1:0] : 2'h0;
  wire logic [1:0] mask_clr = wr_idr ? wdata[1:0] : 2'h0;
  // A fresh event beats a clear in the same cycle
  wire logic [1:0] pend_next = (irq_pending_reg & ~pend_clr) | irq_set;
  wire logic [1:0] mask_next = (irq_mask_reg | mask_set) & ~mask_clr;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_pending_reg <= cfm_pkg::IRQ_RESET;
      irq_mask_reg <= cfm_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_pending_reg <= pend_next;
      irq_mask_reg <= mask_next;
      irq <= |(pend_next & mask_next);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_start_idle;
    start_cmd && !meas_busy;
  endsequence

  property p_start_busy;
    s_start_idle |=> meas_busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not set measurement busy");

  property p_finish_done;
    meas_finish |=> !meas_busy &&
      irq_pending_reg[cfm_pkg::IRQ_DONE_BIT];
  endproperty
  a_finish_done: assert property (p_finish_done)
    else $error("finish did not clear busy and flag done");

  property p_value_latch;
    count_end |=> value_reg == $past(edge_cnt_next);
  endproperty
  a_value_latch: assert property (p_value_latch)
    else $error("value register missed the final count");

  property p_irq_or;
    irq == |(irq_pending_reg & irq_mask_reg);
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("interrupt line differs from masked pending");

  property p_mask_set;
    wr_ier && wdata[0] && !(wr_idr) |=> irq_mask_reg[0];
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("enable-set write did not set mask");

  property p_mask_zero;
    (wr_ier || wr_idr) && wdata[1:0] == 2'h0 |=> $stable(irq_mask_reg);
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("zero write changed the mask");

  property p_refbusy_write;
    wr_mode |=> ref_switch_busy;
  endproperty
  a_refbusy_write: assert property (p_refbusy_write)
    else $error("mode write did not raise reference busy");

  property p_ready_flag;
    $fell(ref_switch_busy) |-> irq_pending_reg[cfm_pkg::IRQ_READY_BIT];
  endproperty
  a_ready_flag: assert property (p_ready_flag)
    else $error("reference ready flag not set");

  property p_set_wins;
    wr_icr && wdata[0] && meas_finish |=> irq_pending_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("done event lost to a clear");

  property p_window;
    meas_state_reg == cfm_pkg::MEAS_COUNT |->
      ref_done_reg < ref_cycle_count;
  endproperty
  a_window: assert property (p_window)
    else $error("window ran past the reference count");

  property p_pend_hold;
    irq_pending_reg[0] && !(wr_icr && wdata[0]) |=> irq_pending_reg[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending flag dropped without a clear");

endmodule

// ---- hdl/cfm_pkg.sv ----
// Constants and types shared by the clock frequency meter
package cfm_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VALUE_W = 24;
  localparam int unsigned IRQ_W = 2;

  // Register offsets (byte addresses)
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_MODE = 10'h004;
  localparam logic [9:0] OFS_STATUS = 10'h008;
  localparam logic [9:0] OFS_VALUE = 10'h00c;
  localparam logic [9:0] OFS_IRQ_ENABLE_SET = 10'h010;
  localparam logic [9:0] OFS_IRQ_ENABLE_CLEAR = 10'h014;
  localparam logic [9:0] OFS_IRQ_MASK = 10'h018;
  localparam logic [9:0] OFS_IRQ_PENDING = 10'h01c;
  localparam logic [9:0] OFS_IRQ_PENDING_CLEAR = 10'h020;
  localparam logic [9:0] OFS_VERSION = 10'h3fc;

  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned REF_SOURCE_SELECT_LSB = 0;
  localparam int unsigned REF_SOURCE_SELECT_W = 3;
  localparam int unsigned REFCNT_LSB = 8;
  localparam int unsigned REFCNT_W = 8;
  localparam int unsigned MSRSEL_LSB = 16;
  localparam int unsigned MSRSEL_W = 5;
  localparam int unsigned REFEN_BIT = 31;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_REFBUSY_BIT = 1;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_READY_BIT = 1;
  localparam int unsigned VERSION_W = 12;

  localparam int unsigned REF_SRC_N = 8;
  localparam int unsigned MSR_SRC_N = 32;

  // Reset values and writable bits
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h801f_ff07;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Reference edges seen before an enable change takes effect
  localparam logic [1:0] REF_SETTLE_EDGES = 2'h2;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ALIGN,
    MEAS_COUNT
  } cfm_meas_e;

endpackage

// ---- hdl/cfm_sync.sv ----
// Two-flop synchroniser for a group of asynchronous clock pins
module cfm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ---- hdl/cfm_ref_switch.sv ----
// Reference clock enable handshake with busy and ready indication
module cfm_ref_switch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en_write,
  input wire logic en_value,
  input wire logic ref_rise,
  output logic ref_on,
  output logic busy,
  output logic ready_pulse
);

  logic target_reg;
  logic [1:0] edge_cnt_reg;

  // Last settle edge; pulse lines up with the busy drop, not after it
  wire logic settle_end = !en_write && busy && ref_rise &&
    (edge_cnt_reg == cfm_pkg::REF_SETTLE_EDGES - 2'h1);

  assign ready_pulse = settle_end;

  // Change waits on edges of the selected source; a dead source hangs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      target_reg <= 1'b0;
      edge_cnt_reg <= 2'h0;
      ref_on <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (en_write) begin
        busy <= 1'b1;
        target_reg <= en_value;
        edge_cnt_reg <= 2'h0;
      end else if (busy && ref_rise) begin
        if (settle_end) begin
          busy <= 1'b0;
          ref_on <= target_reg;
        end else begin
          edge_cnt_reg <= edge_cnt_reg + 2'h1;
        end
      end
    end
  end

  property p_switch_waits;
    @(posedge clk) disable iff (!rstn)
      busy && !ref_rise |=> busy;
  endproperty
  a_switch_waits: assert property (p_switch_waits)
    else $error("reference switch finished without a reference edge");

endmodule

// ---- tb/tb_clock_frequency_meter.sv ----
// Self-checking bench for the clock frequency meter
module tb_clock_frequency_meter;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] VER = 12'h3a5; // Arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] ref_sources = 8'h00;
  logic [31:0] measured_sources = 32'h0000_0000;
  logic ref_clock_on;
  logic irq;
  logic [31:0] rv;
  logic [31:0] mode_now = 32'h0000_0000;
  int cyc = 0;
  int err_total = 0;
  int comparisons = 0;

  cfm_top #(.VERSION_ID(VER)) dut (
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .ref_sources(ref_sources),
    .measured_sources(measured_sources),
    .ref_clock_on(ref_clock_on),
    .irq(irq)
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Ref 0 period 32 clk, ref 1 period 64, ref 2 stopped; measured 4 and 8.
  // Derived from clk so the expected ratios are exact, not statistical.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ref_sources <= {6'h00, cyc[5], cyc[4]};
    measured_sources <= {30'h0, cyc[2], cyc[1]};
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input int tol, input string what);
    comparisons++;
    if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Registered irq changes on the same edge as the flags
  task automatic chk_irq(input logic e);
    @(posedge clk);
    #1 chk({31'h0, irq}, {31'h0, e}, 0, "irq");
  endtask

  function automatic logic [31:0] mw(input logic en, input logic [4:0] m,
                                     input logic [7:0] n, input logic [2:0] s);
    return {en, 10'h000, m, n, 5'h00, s};
  endfunction

  task automatic wait_ref();
    int n;
    n = 0;
    do begin
      rd_reg(cfm_pkg::OFS_STATUS, rv);
      n++;
    end while (rv[1] !== 1'b0 && n < 100);
    chk({31'h0, rv[1]}, 32'h0, 0, "ref busy");
  endtask

  task automatic mode_wait(input logic [31:0] m);
    wr_reg(cfm_pkg::OFS_MODE, m);
    wait_ref();
  endtask

  // Source change: disable, reselect with enable low, then enable
  task automatic switch_ref(input logic [31:0] m);
    mode_wait({1'b0, mode_now[30:0]});
    mode_wait({1'b0, m[30:0]});
    mode_wait(m);
    mode_now = m;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [9:0] a[8];
    a = '{cfm_pkg::OFS_CTRL, cfm_pkg::OFS_MODE, cfm_pkg::OFS_STATUS,
          cfm_pkg::OFS_VALUE, cfm_pkg::OFS_IRQ_MASK, cfm_pkg::OFS_IRQ_PENDING,
          cfm_pkg::OFS_IRQ_PENDING_CLEAR, 10'h100};
    foreach (a[i]) begin
      rd_reg(a[i], rv);
      chk(rv, 32'h0, 0, "reset or unmapped read");
    end
    rd_reg(cfm_pkg::OFS_VERSION, rv);
    chk(rv, {20'h0, VER}, 0, "version");
    @(posedge clk);
    #1 chk(rdata, 32'h0, 0, "read data after its cycle");
    chk({31'h0, ref_clock_on}, 32'h0, 0, "ref off at reset");
    chk({31'h0, irq}, 32'h0, 0, "irq at reset");
    // Only defined mode bits may stick
    mode_wait(32'h7fe0_00f8);
    rd_reg(cfm_pkg::OFS_MODE, rv);
    chk(rv, 32'h0, 0, "mode reserved bits");
  endtask

  task automatic t_ref_up();
    mode_wait(mw(1'b0, 5'h00, 8'h04, 3'h0));
    wr_reg(cfm_pkg::OFS_MODE, mw(1'b1, 5'h00, 8'h04, 3'h0));
    rd_reg(cfm_pkg::OFS_STATUS, rv);
    chk(rv, 32'h2, 0, "ref busy after enable write");
    chk({31'h0, ref_clock_on}, 32'h0, 0, "ref still off");
    wait_ref();
    mode_now = mw(1'b1, 5'h00, 8'h04, 3'h0);
    rd_reg(cfm_pkg::OFS_MODE, rv);
    chk(rv, mode_now, 0, "mode readback");
    chk({31'h0, ref_clock_on}, 32'h1, 0, "ref on");
    rd_reg(cfm_pkg::OFS_IRQ_PENDING, rv);
    chk(rv, 32'h2, 0, "ref ready pending");
    chk_irq(1'b0);
  endtask

  task automatic t_irq();
    wr_reg(cfm_pkg::OFS_IRQ_ENABLE_SET, 32'h0);
    rd_reg(cfm_pkg::OFS_IRQ_MASK, rv);
    chk(rv, 32'h0, 0, "mask after zero set");
    wr_reg(cfm_pkg::OFS_IRQ_ENABLE_SET, 32'h2);
    rd_reg(cfm_pkg::OFS_IRQ_MASK, rv);
    chk(rv, 32'h2, 0, "mask set");
    chk_irq(1'b1);
    wr_reg(cfm_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h0);
    rd_reg(cfm_pkg::OFS_IRQ_MASK, rv);
    chk(rv, 32'h2, 0, "mask after zero clear");
    wr_reg(cfm_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h2);
    rd_reg(cfm_pkg::OFS_IRQ_MASK, rv);
    chk(rv, 32'h0, 0, "mask cleared");
    chk_irq(1'b0);
    wr_reg(cfm_pkg::OFS_IRQ_ENABLE_SET, 32'h3);
    chk_irq(1'b1);
    wr_reg(cfm_pkg::OFS_IRQ_PENDING_CLEAR, 32'h2);
    rd_reg(cfm_pkg::OFS_IRQ_PENDING, rv);
    chk(rv, 32'h0, 0, "pending cleared");
    chk_irq(1'b0);
  endtask

  task automatic t_meas(input logic [2:0] s, input logic [4:0] m,
                        input logic [7:0] n, input logic [31:0] ratio);
    int k;
    switch_ref(mw(1'b1, m, n, s));
    wr_reg(cfm_pkg::OFS_IRQ_PENDING_CLEAR, 32'h3);
    // Start just after a reference edge, so a zero count still reads busy
    while (cyc[4:0] != 5'h12) begin
      @(posedge clk);
    end
    wr_reg(cfm_pkg::OFS_CTRL, 32'h1);
    rd_reg(cfm_pkg::OFS_STATUS, rv);
    chk(rv, 32'h1, 0, "busy after start");
    wr_reg(cfm_pkg::OFS_CTRL, 32'h1);
    k = 0;
    do begin
      rd_reg(cfm_pkg::OFS_STATUS, rv);
      k++;
    end while (rv[0] !== 1'b0 && k < 6000);
    chk(rv, 32'h0, 0, "busy cleared");
    rd_reg(cfm_pkg::OFS_VALUE, rv);
    chk(rv, ratio * n, (n == 8'h00) ? 0 : 1, "result");
    rd_reg(cfm_pkg::OFS_IRQ_PENDING, rv);
    chk(rv, 32'h1, 0, "done pending");
    chk_irq(1'b1);
    wr_reg(cfm_pkg::OFS_IRQ_PENDING_CLEAR, 32'h1);
    chk_irq(1'b0);
  endtask

  // A stopped reference hangs both the switch and a measurement
  task automatic t_stop();
    mode_wait({1'b0, mode_now[30:0]});
    wr_reg(cfm_pkg::OFS_MODE, mw(1'b1, 5'h00, 8'h02, 3'h2));
    wr_reg(cfm_pkg::OFS_CTRL, 32'h1);
    repeat (300) @(posedge clk);
    rd_reg(cfm_pkg::OFS_STATUS, rv);
    chk(rv, 32'h3, 0, "hung on stopped reference");
    chk({31'h0, ref_clock_on}, 32'h0, 0, "ref stays off");
    rd_reg(cfm_pkg::OFS_IRQ_PENDING, rv);
    // Only the ready event of the shutdown is pending
    chk(rv, 32'h2, 0, "no done on stopped reference");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(cfm_pkg::OFS_STATUS, rv);
    // Meter idle and reference off before the run stops its clock
    chk(rv, 32'h0, 0, "status after second reset");
    chk({31'h0, ref_clock_on}, 32'h0, 0, "ref off at end");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_ref_up();
    t_irq();
    t_meas(3'h0, 5'h00, 8'h04, 32'd8);
    t_meas(3'h0, 5'h01, 8'h08, 32'd4);
    t_meas(3'h1, 5'h00, 8'h03, 32'd16);
    t_meas(3'h0, 5'h00, 8'h00, 32'd8);
    t_meas(3'h0, 5'h00, 8'hff, 32'd8);
    t_stop();
    summarize();
  end

endmodule
